// ---- rtl/ppb_pkg.sv ----
package ppb_pkg;
	// Shared memory geometry
	localparam int RAM_AW = 15;
	localparam int RAM_DW = 16;
	localparam int RAM_AW_MIN = 4;
	localparam int RAM_AW_MAX = 18;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	// Register byte offsets; shared memory words sit above RAM_SEL_BIT
	localparam logic [31:0] OFF_CONFIG = 32'h0000_0000;
	localparam logic [31:0] OFF_IRQ_EN = 32'h0000_0004;
	localparam logic [31:0] OFF_STATUS = 32'h0000_0008;
	localparam int RAM_SEL_BIT = 20;

	// Configuration register fields
	localparam int CFG_BROADCAST_FLAG_SEP = 0;
	localparam int CFG_TOGGLE_GUARD = 1;
	localparam int CFG_BROADCAST_FLAG_INVALID = 2;
	localparam logic [2:0] CFG_RESET = 3'h0;

	// Interrupt enable register fields
	localparam int IE_BROADCAST_FLAG = 0;
	localparam int IE_ACCESS = 1;
	localparam logic [1:0] IE_RESET = 2'h0;

	// Status register fields
	localparam int ST_CLEARING = 0;
	localparam int ST_ENGINE_BUSY = 1;
	localparam int ST_LAST_SEL = 2;
	localparam int ST_COUNT_LSB = 16;

	// Descriptor control word fields
	localparam int CW_PP_ACTIVE = 0;
	localparam int CW_PP_STOP = 1;
	localparam int CW_PP_SELECT = 2;
	localparam int CW_ACTIVE_BUF = 3;
	localparam int CW_NEXT_SEL = 4;
	localparam int CW_BROADCAST_FLAG_IRQ = 13;
	localparam int CW_ACCESS_IRQ = 14;

	// Descriptor word offsets from N, data structure offsets
	localparam logic [1:0] DESC_CW = 2'h0;
	localparam logic [1:0] DESC_PTR_A = 2'h1;
	localparam logic [1:0] DESC_PTR_B = 2'h2;
	localparam logic [1:0] DESC_PTR_BC = 2'h3;
	localparam logic [1:0] BUF_MIW = 2'h0;
	localparam logic [1:0] BUF_TIME = 2'h1;

	// Message information word
	localparam int MIW_BROADCAST_FLAG_FLAG = 13;

	typedef enum {
		ST_IDLE, ST_CW_RD, ST_CW_WAIT, ST_CW_WR, ST_PTR_RD, ST_PTR_WAIT,
		ST_RUN, ST_MIW_WR, ST_TT_WR, ST_CW2_RD, ST_CW2_WAIT, ST_CW2_WR
	} eng_state_t;
endpackage

// ---- rtl/ram_port_if.sv ----
`timescale 1ns/100ps
interface ram_port_if #(parameter int AW = 15, parameter int DW = 16);
	logic en;
	logic we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;

	modport ctrl (output en, output we, output addr, output wdata,
		input rdata);
	modport mem (input en, input we, input addr, input wdata,
		output rdata);
endinterface

// ---- rtl/shared_ram.sv ----
`timescale 1ns/100ps
module shared_ram #(
	parameter int AW = 15,
	parameter int DW = 16
) (
	// Clock
	input wire logic hclk,
	// Access port
	ram_port_if.mem port
);
	logic [DW-1:0] store [0:(1<<AW)-1];
	logic [DW-1:0] rdata_reg;

	// Read data come one cycle after the access, from a register
	always_ff @(posedge hclk)
	begin
		if (port.en && port.we)
			store[port.addr] <= port.wdata;
		if (port.en && !port.we)
			rdata_reg <= store[port.addr];
	end

	assign port.rdata = rdata_reg;
endmodule

// ---- rtl/pingpong_buffer_manager.sv ----
// Operation
// - Separate A/B pairs per transmit and receive
// - Descriptor: control, pointer A, B, broadcast
// - Running alternation sets pingpong_active
// - next_buffer_select picks pointer A or B
// - Pointer words are never written
// - Good message inverts next_buffer_select
// - Guard blocks toggle on faulty messages
// - Without guard, illegal and busy toggle
// - Guard: illegal word count never toggles
// - Reset clears whole shared memory
// - Reset leaves next_buffer_select at A
// - Stop clears active, holds same buffer
// - Clearing stop resumes, sets active
// - Separation puts broadcasts in broadcast buffer
// - Broadcast transmit stores info, sends nothing (code suppresses data only for separated broadcasts)
// - Separated broadcast leaves select unchanged
// - Broadcast irq when both enables set
// - Merged broadcast flagged, toggles normally
// - Access irq on any message when both enables set
`timescale 1ns/100ps
module pingpong_buffer_manager
	import ppb_pkg::*;
#(
	parameter int AW = RAM_AW
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	// Message start from the protocol engine
	input wire logic msg_start,
	input wire logic [15:0] msg_desc_addr,
	input wire logic msg_broadcast,
	input wire logic msg_transmit,
	// Message completion from the protocol engine
	input wire logic msg_done,
	input wire logic [15:0] msg_info,
	input wire logic [15:0] msg_time,
	input wire logic msg_incomplete,
	input wire logic msg_illegal,
	input wire logic msg_busy,
	input wire logic msg_error,
	input wire logic msg_wc_illegal,
	// Buffer selection and status to the protocol engine
	output logic mgr_ready,
	output logic buf_valid,
	output logic [15:0] buf_ptr,
	output logic buf_is_b,
	output logic tx_data_suppress,
	// Host interrupt
	output logic message_interrupt
);
	if (AW < RAM_AW_MIN || AW > RAM_AW_MAX || AW > RAM_DW)
	begin : g_bad_aw
		$error("pingpong_buffer_manager: AW out of range");
	end

	localparam logic [AW-1:0] ADDR_LAST = '1;

	ram_port_if #(.AW(AW), .DW(RAM_DW)) ram ();

	shared_ram #(.AW(AW), .DW(RAM_DW)) u_ram (
		.hclk(hclk),
		.port(ram)
	);

	function automatic logic [AW-1:0] word_at(input logic [AW-1:0] base,
		input logic [1:0] off);
		return base + AW'(off);
	endfunction

	function automatic logic toggle_allowed(input logic guard,
		input logic incomplete, input logic illegal, input logic busy,
		input logic err, input logic wc_illegal);
		if (guard)
			return !(incomplete || illegal || busy || err || wc_illegal);
		return !(incomplete || err);
	endfunction

	// Software-visible state
	logic [2:0] cfg_reg;
	logic [1:0] ie_reg;
	logic [15:0] msg_count_reg;
	logic last_sel_reg;

	// Memory clear after reset
	logic clr_active_reg;
	logic [AW-1:0] clr_addr_reg;

	// Engine state
	eng_state_t state_reg;
	logic [AW-1:0] desc_reg;
	logic [AW-1:0] ptr_reg;
	logic [1:0] off_reg;
	logic [15:0] cw_reg;
	logic [15:0] miw_reg;
	logic [15:0] time_reg;
	logic broadcast_flag_reg;
	logic tx_reg;
	logic use_bc_reg;
	logic [4:0] fault_reg;

	// AHB data phase
	logic ahb_busy_reg;
	logic ahb_write_reg;
	logic ahb_got_reg;
	logic [31:0] ahb_addr_reg;

	logic bc_sep;
	logic ahb_accept;
	logic ahb_is_ram;
	logic ahb_grant;
	logic eng_en;
	logic eng_we;
	logic [AW-1:0] eng_addr;
	logic [15:0] eng_wdata;
	logic [15:0] rd;
	logic pp_run;

	assign bc_sep = cfg_reg[CFG_BROADCAST_FLAG_SEP] && !cfg_reg[CFG_BROADCAST_FLAG_INVALID];
	assign ahb_accept = hsel && htrans[1] && hready;
	assign ahb_is_ram = ahb_addr_reg[RAM_SEL_BIT];
	assign rd = ram.rdata;
	assign pp_run = rd[CW_PP_SELECT] && !rd[CW_PP_STOP];

	// Engine memory requests; it never addresses pointer words for writing
	always_comb
	begin
		eng_en = 1'b0;
		eng_we = 1'b0;
		eng_addr = desc_reg;
		eng_wdata = cw_reg;
		case (state_reg)
			ST_CW_RD, ST_CW2_RD:
				eng_en = 1'b1;
			ST_CW_WR, ST_CW2_WR:
			begin
				eng_en = 1'b1;
				eng_we = 1'b1;
			end
			ST_PTR_RD:
			begin
				eng_en = 1'b1;
				eng_addr = word_at(desc_reg, off_reg);
			end
			ST_MIW_WR:
			begin
				eng_en = 1'b1;
				eng_we = 1'b1;
				eng_addr = word_at(ptr_reg, BUF_MIW);
				eng_wdata = miw_reg;
			end
			ST_TT_WR:
			begin
				eng_en = 1'b1;
				eng_we = 1'b1;
				eng_addr = word_at(ptr_reg, BUF_TIME);
				eng_wdata = time_reg;
			end
			default:
				eng_en = 1'b0;
		endcase
	end

	// Clearing first, then the engine; the host waits in its data phase
	always_comb
	begin
		ahb_grant = 1'b0;
		ram.en = 1'b0;
		ram.we = 1'b0;
		ram.addr = eng_addr;
		ram.wdata = eng_wdata;
		if (clr_active_reg)
		begin
			ram.en = 1'b1;
			ram.we = 1'b1;
			ram.addr = clr_addr_reg;
			ram.wdata = '0;
		end
		else if (eng_en)
		begin
			ram.en = 1'b1;
			ram.we = eng_we;
		end
		else if (ahb_busy_reg && ahb_is_ram && !ahb_got_reg)
		begin
			ahb_grant = 1'b1;
			ram.en = 1'b1;
			ram.we = ahb_write_reg;
			ram.addr = ahb_addr_reg[AW+1:2];
			ram.wdata = hwdata[RAM_DW-1:0];
		end
	end

	// Whole memory is zeroed after reset, so every select bit starts at A
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			clr_active_reg <= 1'b1;
			clr_addr_reg <= '0;
		end
		else if (clr_active_reg)
		begin
			clr_addr_reg <= clr_addr_reg + 1'b1;
			if (clr_addr_reg == ADDR_LAST)
				clr_active_reg <= 1'b0;
		end
	end

	// Message engine
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= ST_IDLE;
			desc_reg <= '0;
			ptr_reg <= '0;
			off_reg <= DESC_PTR_A;
			cw_reg <= '0;
			miw_reg <= '0;
			time_reg <= '0;
			broadcast_flag_reg <= 1'b0;
			tx_reg <= 1'b0;
			use_bc_reg <= 1'b0;
			fault_reg <= '0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
					if (msg_start && !clr_active_reg)
					begin
						desc_reg <= msg_desc_addr[AW-1:0];
						broadcast_flag_reg <= msg_broadcast;
						tx_reg <= msg_transmit;
						state_reg <= ST_CW_RD;
					end
				ST_CW_RD:
					state_reg <= ST_CW_WAIT;
				ST_CW_WAIT:
				begin
					cw_reg <= rd;
					if (rd[CW_PP_SELECT])
						cw_reg[CW_PP_ACTIVE] <= pp_run;
					use_bc_reg <= broadcast_flag_reg && bc_sep;
					if (broadcast_flag_reg && bc_sep)
						off_reg <= DESC_PTR_BC;
					else
					begin
						// While stopped the select bit is frozen on the active buffer
						off_reg <= rd[CW_NEXT_SEL] ? DESC_PTR_B : DESC_PTR_A;
						cw_reg[CW_ACTIVE_BUF] <= rd[CW_NEXT_SEL];
					end
					state_reg <= ST_CW_WR;
				end
				ST_CW_WR:
					state_reg <= ST_PTR_RD;
				ST_PTR_RD:
					state_reg <= ST_PTR_WAIT;
				ST_PTR_WAIT:
				begin
					ptr_reg <= rd[AW-1:0];
					state_reg <= ST_RUN;
				end
				ST_RUN:
					if (msg_done)
					begin
						miw_reg <= msg_info;
						miw_reg[MIW_BROADCAST_FLAG_FLAG] <= broadcast_flag_reg;
						time_reg <= msg_time;
						fault_reg <= {msg_incomplete, msg_illegal, msg_busy,
							msg_error, msg_wc_illegal};
						state_reg <= ST_MIW_WR;
					end
				ST_MIW_WR:
					state_reg <= ST_TT_WR;
				ST_TT_WR:
					state_reg <= ST_CW2_RD;
				ST_CW2_RD:
					state_reg <= ST_CW2_WAIT;
				ST_CW2_WAIT:
				begin
					// Re-read so host edits made during the message survive
					cw_reg <= rd;
					if (rd[CW_PP_SELECT])
						cw_reg[CW_PP_ACTIVE] <= pp_run;
					if (pp_run && !use_bc_reg && toggle_allowed(
						cfg_reg[CFG_TOGGLE_GUARD], fault_reg[4], fault_reg[3],
						fault_reg[2], fault_reg[1], fault_reg[0]))
						cw_reg[CW_NEXT_SEL] <= !rd[CW_NEXT_SEL];
					state_reg <= ST_CW2_WR;
				end
				ST_CW2_WR:
					state_reg <= ST_IDLE;
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// Outputs toward the protocol engine
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mgr_ready <= 1'b0;
			buf_valid <= 1'b0;
			buf_ptr <= '0;
			buf_is_b <= 1'b0;
			tx_data_suppress <= 1'b0;
		end
		else
		begin
			mgr_ready <= !clr_active_reg && state_reg == ST_IDLE && !msg_start;
			buf_valid <= state_reg == ST_PTR_WAIT;
			if (state_reg == ST_PTR_WAIT)
			begin
				buf_ptr <= rd;
				buf_is_b <= off_reg == DESC_PTR_B;
				tx_data_suppress <= use_bc_reg && tx_reg;
			end
		end
	end

	// Message interrupt, one cycle per qualifying message
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			message_interrupt <= 1'b0;
		else
			message_interrupt <= state_reg == ST_CW2_WAIT &&
				((broadcast_flag_reg && rd[CW_BROADCAST_FLAG_IRQ] && ie_reg[IE_BROADCAST_FLAG]) ||
				(rd[CW_ACCESS_IRQ] && ie_reg[IE_ACCESS]));
	end

	// Message counter and last buffer used, for status
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			msg_count_reg <= '0;
			last_sel_reg <= 1'b0;
		end
		else if (state_reg == ST_CW2_WR)
		begin
			msg_count_reg <= msg_count_reg + 1'b1;
			last_sel_reg <= off_reg == DESC_PTR_B;
		end
	end

	// AHB-Lite slave: every transfer takes at least one wait state
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ahb_busy_reg <= 1'b0;
			ahb_write_reg <= 1'b0;
			ahb_got_reg <= 1'b0;
			ahb_addr_reg <= '0;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
			hrdata <= '0;
			cfg_reg <= CFG_RESET;
			ie_reg <= IE_RESET;
		end
		else if (!ahb_busy_reg)
		begin
			hreadyout <= 1'b1;
			if (ahb_accept)
			begin
				ahb_busy_reg <= 1'b1;
				ahb_write_reg <= hwrite;
				ahb_addr_reg <= haddr;
				ahb_got_reg <= 1'b0;
				hreadyout <= 1'b0;
			end
		end
		else if (!ahb_is_ram)
		begin
			ahb_busy_reg <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= '0;
			if (ahb_write_reg && ahb_addr_reg == OFF_CONFIG)
				cfg_reg <= hwdata[2:0];
			if (ahb_write_reg && ahb_addr_reg == OFF_IRQ_EN)
				ie_reg <= hwdata[1:0];
			if (!ahb_write_reg && ahb_addr_reg == OFF_CONFIG)
				hrdata <= {29'h0000_0000, cfg_reg};
			if (!ahb_write_reg && ahb_addr_reg == OFF_IRQ_EN)
				hrdata <= {30'h0000_0000, ie_reg};
			if (!ahb_write_reg && ahb_addr_reg == OFF_STATUS)
			begin
				hrdata[ST_CLEARING] <= clr_active_reg;
				hrdata[ST_ENGINE_BUSY] <= state_reg != ST_IDLE;
				hrdata[ST_LAST_SEL] <= last_sel_reg;
				hrdata[ST_COUNT_LSB +: 16] <= msg_count_reg;
			end
		end
		else if (ahb_grant && ahb_write_reg)
		begin
			ahb_busy_reg <= 1'b0;
			hreadyout <= 1'b1;
		end
		else if (ahb_grant)
			ahb_got_reg <= 1'b1;
		else if (ahb_got_reg)
		begin
			ahb_busy_reg <= 1'b0;
			ahb_got_reg <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= {16'h0000, rd};
		end
	end
endmodule

// ---- bench/ppb_chk.sv ----
`timescale 1ns/100ps
module ppb_chk
	import ppb_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Watched ports
	input wire logic msg_start,
	input wire logic msg_done,
	input wire logic mgr_ready,
	input wire logic buf_valid,
	input wire logic [15:0] buf_ptr,
	input wire logic [1:0] hresp,
	input wire logic message_interrupt
);
	logic run_reg;

	// Done counts only while a buffer has been handed out
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			run_reg <= 1'b0;
		else if (buf_valid)
			run_reg <= 1'b1;
		else if (msg_done)
			run_reg <= 1'b0;
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_resp_okay: assert property (hresp == HRESP_OKAY)
		else $error("response not okay");
	a_start_valid: assert property (msg_start && mgr_ready |-> ##6 buf_valid)
		else $error("buffer choice late");
	a_valid_pulse: assert property (buf_valid |=> !buf_valid)
		else $error("buffer valid too long");
	a_ptr_hold: assert property (!buf_valid |-> $stable(buf_ptr))
		else $error("pointer moved");
	a_ready_drop: assert property (msg_start && mgr_ready |=> !mgr_ready)
		else $error("ready kept high");
	a_irq_cause: assert property (message_interrupt |-> $past(msg_done, 5))
		else $error("interrupt without message");
	a_irq_pulse: assert property (message_interrupt |=> !message_interrupt)
		else $error("interrupt too long");
	a_done_ready: assert property (run_reg && msg_done |->
		!mgr_ready [*7] ##1 mgr_ready)
		else $error("ready timing wrong");
endmodule

bind pingpong_buffer_manager ppb_chk ppb_chk_i (.hclk, .hresetn, .msg_start,
	.msg_done, .mgr_ready, .buf_valid, .buf_ptr, .hresp, .message_interrupt);

// ---- bench/msg_engine.sv ----
`timescale 1ns/100ps
module msg_engine (
	// Clock
	input wire logic hclk,
	// From the manager
	input wire logic buf_valid,
	input wire logic mgr_ready,
	// To the manager
	output logic msg_start,
	output logic msg_broadcast,
	output logic msg_transmit,
	output logic msg_done,
	output logic [15:0] msg_info,
	output logic [15:0] msg_time,
	output logic [4:0] msg_flags
);
	initial
	begin
		{msg_start, msg_broadcast, msg_transmit, msg_done} = 4'h0;
		{msg_info, msg_time, msg_flags} = '0;
	end

	// Descriptor block sits at word 0 of shared memory
	task automatic run(input logic bc, tx, input logic [4:0] fl,
		input logic [15:0] info, tm);
		msg_start <= 1'b1;
		msg_broadcast <= bc;
		msg_transmit <= tx;
		@(posedge hclk);
		msg_start <= 1'b0;
		do @(posedge hclk); while (buf_valid !== 1'b1);
		msg_done <= 1'b1;
		msg_info <= info;
		msg_time <= tm;
		msg_flags <= fl;
		@(posedge hclk);
		// Released lines must not keep the last value
		msg_done <= 1'b0;
		msg_info <= ~info;
		msg_time <= ~tm;
		msg_flags <= ~fl;
		do @(posedge hclk); while (mgr_ready !== 1'b1);
	endtask
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/100ps
module tb;
	import ppb_pkg::*;
	localparam int AW = 6;
	localparam logic [15:0] PA = 16'h0010;
	localparam logic [15:0] PB = 16'h0020;
	localparam logic [15:0] PC = 16'h0030;
	logic hclk = 0;
	logic hresetn = 0;
	logic hwrite = 0;
	logic [1:0] htrans = HTRANS_IDLE;
	logic [31:0] haddr = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] hrdata;
	logic [1:0] hresp;
	logic hreadyout, mgr_ready, buf_valid, buf_is_b, tx_data_suppress;
	logic message_interrupt, msg_start, msg_broadcast, msg_transmit;
	logic msg_done;
	logic [15:0] msg_info, msg_time, buf_ptr;
	logic [4:0] msg_flags;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	int irq_n = 0;

	always #2.5 hclk = ~hclk;

	pingpong_buffer_manager #(.AW(AW)) pingpong_buffer_manager_i (.hclk,
		.hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.msg_start, .msg_desc_addr(16'h0000), .msg_broadcast, .msg_transmit,
		.msg_done, .msg_info, .msg_time, .msg_incomplete(msg_flags[0]),
		.msg_illegal(msg_flags[1]), .msg_busy(msg_flags[2]),
		.msg_error(msg_flags[3]), .msg_wc_illegal(msg_flags[4]), .mgr_ready,
		.buf_valid, .buf_ptr, .buf_is_b, .tx_data_suppress,
		.message_interrupt);

	msg_engine msg_engine_i (.hclk, .buf_valid, .mgr_ready, .msg_start,
		.msg_broadcast, .msg_transmit, .msg_done, .msg_info, .msg_time,
		.msg_flags);

	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// A hang costs a mismatch and ends the run
	always @(posedge hclk)
	begin
		cyc++;
		if (message_interrupt === 1'b1)
			irq_n++;
		if (cyc == 20000)
		begin
			error_cnt++;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] s, e, input string what);
		compares++;
		if (s !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, d,
		output logic [31:0] r);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= HTRANS_IDLE;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	function automatic logic [31:0] ra(input logic [15:0] w);
		return 32'h0010_0000 + 32'({w, 2'b00});
	endfunction

	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask

	task automatic cr(input logic [31:0] a, e, input string what);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0000_0000, r);
		chk(r, e, what);
	endtask

	initial
	begin
		logic [31:0] r, cw;
		logic [15:0] ex, info, tm;
		logic [4:0] fl;
		logic [1:0] ie;
		logic bc, tx, st, gd, sp, xs, tg, nb, xi, iv;
		int i0;
		r = $urandom(59);
		nb = 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		cr(OFF_CONFIG, 32'(CFG_RESET), "config");
		cr(OFF_IRQ_EN, 32'(IE_RESET), "irq_en");
		cr(32'h0000_0040, 32'h0000_0000, "unmapped");
		cr(ra(PA), 32'h0000_0000, "cleared");
		while (mgr_ready !== 1'b1) @(posedge hclk);
		wr(ra(16'h0001), 32'(PA));
		wr(ra(16'h0002), 32'(PB));
		wr(ra(16'h0003), 32'(PC));
		for (int k = 0; k < 24; k++)
		begin
			r = $urandom;
			// First message is plain so that buffer A after reset shows
			bc = r[0] & (k > 0);
			tx = r[1];
			st = r[2] & r[3] & (k > 0);
			gd = r[4];
			sp = r[5];
			iv = r[12];
			ie = r[7:6];
			fl = (r[8] || k == 0) ? 5'h00 : 5'h01 << (r[11:9] % 3'd5);
			info = 16'($urandom);
			tm = 16'($urandom);
			cw = ($urandom & 32'h0000_FFE0) | 32'h0000_0004;
			cw = cw | 32'(st) << CW_PP_STOP | 32'(nb) << CW_NEXT_SEL;
			wr(OFF_CONFIG, 32'(sp) << CFG_BROADCAST_FLAG_SEP |
				32'(gd) << CFG_TOGGLE_GUARD | 32'(iv) << CFG_BROADCAST_FLAG_INVALID);
			wr(OFF_IRQ_EN, 32'(ie));
			wr(ra(16'h0000), cw);
			i0 = irq_n;
			msg_engine_i.run(bc, tx, fl, info, tm);
			xs = sp & !iv & bc;
			ex = xs ? PC : nb ? PB : PA;
			chk(32'(buf_ptr), 32'(ex), "buf_ptr");
			if (!xs)
				chk(32'(buf_is_b), 32'(nb), "buf_is_b");
			chk(32'(tx_data_suppress), 32'(xs & tx), "suppress");
			tg = !st && !xs && (gd ? fl == 5'h00 : !(fl[0] | fl[3]));
			nb = nb ^ tg;
			xi = cw[CW_BROADCAST_FLAG_IRQ] & ie[IE_BROADCAST_FLAG] & bc;
			xi = xi | (cw[CW_ACCESS_IRQ] & ie[IE_ACCESS]);
			chk(32'(irq_n - i0), 32'(xi), "irq");
			ahb(1'b0, ra(16'h0000), 32'h0000_0000, r);
			cw = (cw & ~32'h0000_0019) | 32'(!st) | 32'(nb) << CW_NEXT_SEL;
			// Active buffer records the pointer chosen at message start
			cw = cw | 32'(ex == PB) << CW_ACTIVE_BUF;
			chk(r, cw, "control");
			info[MIW_BROADCAST_FLAG_FLAG] = bc;
			cr(ra(ex), 32'(info), "miw");
			cr(ra(ex + 16'h0001), 32'(tm), "time");
			cr(ra(16'h0001), 32'(PA), "ptr_a");
			cr(ra(16'h0002), 32'(PB), "ptr_b");
			ahb(1'b0, OFF_STATUS, 32'h0000_0000, r);
			chk(32'(r[31:ST_COUNT_LSB]), 32'(k + 1), "count");
			chk(32'(r[2:0]), 32'(ex == PB) << ST_LAST_SEL, "status");
			$display("test %0d done", k);
		end
		end_sim();
	end
endmodule
